// [rtl/pgsc_top.sv]
`timescale 1ns/1ps
`include "pgsc_cfg.svh"
module pgsc_top
	import pgsc_pkg::*;
#(
	parameter int CNT_W = `PGSC_CNT_W,
	parameter int LOW_CYC = `PGSC_LOW_CYC,
	parameter int HIGH_CYC = `PGSC_HIGH_CYC,
	parameter int PARK_CYC = `PGSC_PARK_CYC
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Asynchronous inputs
	input wire logic power_good_in,
	input wire logic supply_sense_in,
	input wire logic standby_req_in,
	// Park handshake
	input wire logic park_done,
	// Status and control outputs
	output logic ctrl_reset_n,
	output logic park_req,
	output logic active_mode,
	output logic standby_mode,
	output logic power_good_ok,
	output logic supply_ok
);
	// ----------------------------------------
	// Synchroniser
	// ----------------------------------------
	// Raw pins cross into the clock domain here and nowhere else
	pgsc_sync_if sync_bus ();
	pgsc_sync u_sync (
		.clock(clock),
		.rst_n(rst_n),
		.power_good_in(power_good_in),
		.supply_sense_in(supply_sense_in),
		.standby_req_in(standby_req_in),
		.sync(sync_bus)
	);
	// Synchronised levels, the only view of the pins that the logic below reads
	wire logic pg_s = sync_bus.pg_s;
	wire logic sense_s = sync_bus.sense_s;
	wire logic standby_s = sync_bus.standby_s;

	// ----------------------------------------
	// Qualification counters
	// ----------------------------------------
	// Counting stops at all ones, so a very long run never wraps into a short one
	function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
		sat_inc = (v == {CNT_W{1'b1}}) ? v : v + {{(CNT_W-1){1'b0}}, 1'b1};
	endfunction : sat_inc

	// Limits cut to the counter width
	localparam logic [CNT_W-1:0] LOW_LIM = CNT_W'(LOW_CYC);
	localparam logic [CNT_W-1:0] HIGH_LIM = CNT_W'(HIGH_CYC);
	localparam logic [CNT_W-1:0] PARK_LIM = CNT_W'(PARK_CYC);

	// Run lengths of the low and high levels, and time spent parked
	logic [CNT_W-1:0] low_cnt_reg;
	logic [CNT_W-1:0] high_cnt_reg;
	logic [CNT_W-1:0] park_cnt_reg;
	logic [CNT_W-1:0] low_cnt_next;
	logic [CNT_W-1:0] high_cnt_next;
	logic [CNT_W-1:0] park_cnt_next;
	logic pg_ok_reg;
	logic pg_ok_next;

	// Counters restart on each edge, so short pulses never reach a limit
	assign low_cnt_next = pg_s ? '0 : sat_inc(low_cnt_reg); // see [R5]
	assign high_cnt_next = pg_s ? sat_inc(high_cnt_reg) : '0; // see [R7]
	wire logic low_hit = !pg_s && (low_cnt_next >= LOW_LIM); // see [R4]
	wire logic high_hit = pg_s && (high_cnt_next >= HIGH_LIM); // see [R7]
	// Qualified level: set by long high, cleared by long low only
	assign pg_ok_next = high_hit ? 1'b1 : (low_hit ? 1'b0 : pg_ok_reg); // see [R1] [R5]

	// ----------------------------------------
	// Power state machine
	// ----------------------------------------
	pgsc_state_e state_reg;
	pgsc_state_e state_next;
	// The park sequence lies outside; its done pulse or the counted length ends it
	wire logic park_over = park_done || (park_cnt_reg >= PARK_LIM);

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			PGSC_RESET: if (pg_ok_reg && sense_s) state_next = PGSC_RUN; // see [R1]
			PGSC_RUN: if (!pg_ok_reg) state_next = PGSC_PARK; // see [R4]
			PGSC_PARK: if (park_over) state_next = PGSC_HOLD; // see [R4]
			PGSC_HOLD: state_next = PGSC_RESET; // see [R6]
			default: state_next = PGSC_RESET;
		endcase
	end
	// Park time counts only while parked and restarts on every entry
	assign park_cnt_next = (state_reg == PGSC_PARK) ? sat_inc(park_cnt_reg) : '0;

	// Output next values
	wire logic run_next = (state_next == PGSC_RUN);
	wire logic act_next = run_next && standby_s; // see [R10]
	wire logic stb_next = !(run_next && standby_s); // see [R11]

	// ----------------------------------------
	// State registers
	// ----------------------------------------
	// Counters, qualified level and state advance together
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= PGSC_RESET;
			low_cnt_reg <= '0;
			high_cnt_reg <= '0;
			park_cnt_reg <= '0;
			pg_ok_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			low_cnt_reg <= low_cnt_next;
			high_cnt_reg <= high_cnt_next;
			park_cnt_reg <= park_cnt_next;
			pg_ok_reg <= pg_ok_next;
		end
	end

	// Registered outputs
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reset_n <= 1'b0;
			park_req <= 1'b0;
			active_mode <= 1'b0;
			standby_mode <= 1'b1;
			power_good_ok <= 1'b0;
			supply_ok <= 1'b0;
		end else begin
			ctrl_reset_n <= run_next || (state_next == PGSC_PARK); // see [R6]
			park_req <= (state_next == PGSC_PARK); // see [R4]
			active_mode <= act_next;
			standby_mode <= stb_next;
			power_good_ok <= pg_ok_next;
			supply_ok <= sense_s;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	AST_GLITCH_IGNORED: assert property (@(posedge clock) disable iff (!rst_n) // see [R5]
		(state_reg == PGSC_RUN) && pg_s && $past(low_cnt_reg) < LOW_LIM - 1 |=> pg_ok_reg)
		else $error("Short low pulse dropped qualified power good");
	AST_LOW_STARTS_PARK: assert property (@(posedge clock) disable iff (!rst_n) // see [R4]
		(state_reg == PGSC_RUN) && !pg_ok_reg |=> park_req && state_reg == PGSC_PARK)
		else $error("Lost power good did not start a park");
	AST_PARK_THEN_RESET: assert property (@(posedge clock) disable iff (!rst_n) // see [R4]
		(state_reg == PGSC_PARK) && park_over |=> (state_reg == PGSC_HOLD) ##1 !ctrl_reset_n)
		else $error("Park was not followed by a controller reset");
	AST_HOLD_WHILE_LOW: assert property (@(posedge clock) disable iff (!rst_n) // see [R6]
		(state_reg == PGSC_RESET) && !pg_ok_reg |=> !ctrl_reset_n)
		else $error("Controller left reset while power good low");
	AST_HIGH_QUAL: assert property (@(posedge clock) disable iff (!rst_n) // see [R7]
		$rose(pg_ok_reg) |-> $past(high_cnt_reg) >= HIGH_LIM - 1)
		else $error("Power good accepted before minimum high time");
	AST_LEAVE_RESET: assert property (@(posedge clock) disable iff (!rst_n) // see [R1]
		(state_reg == PGSC_RESET) && pg_ok_reg && sense_s |=> ctrl_reset_n)
		else $error("Qualified power good did not release reset");
	AST_ACTIVE: assert property (@(posedge clock) disable iff (!rst_n) // see [R10]
		(state_next == PGSC_RUN) && standby_s |=> active_mode && !standby_mode)
		else $error("Standby request high did not give active mode");
	AST_STANDBY: assert property (@(posedge clock) disable iff (!rst_n) // see [R11]
		!standby_s |=> standby_mode && !active_mode)
		else $error("Standby request low did not give standby mode");
	AST_SYNC_DELAY: assert property (@(posedge clock) disable iff (!rst_n) // see [R12]
		pg_s |-> $past(power_good_in, 2))
		else $error("Power good sample skipped the synchroniser");

	// ----------------------------------------
	// Checks on qualification
	// ----------------------------------------
	// The qualified level may only drop after a full low run
	AST_LOW_QUAL: assert property (@(posedge clock) disable iff (!rst_n) // see [R5]
		$fell(pg_ok_reg) |-> $past(low_cnt_reg) >= LOW_LIM - 1)
		else $error("Power good dropped before minimum low time");
	// A qualified level only drops while the synchronised pin is low
	AST_LOW_LEVEL: assert property (@(posedge clock) disable iff (!rst_n) // see [R5]
		$fell(pg_ok_reg) |-> !$past(pg_s))
		else $error("Power good dropped while the pin was high");
	// The status output mirrors the internal qualified level
	AST_OK_MIRROR: assert property (@(posedge clock) disable iff (!rst_n) // see [R1]
		power_good_ok == pg_ok_reg)
		else $error("Power good status differs from the qualified level");

	// ----------------------------------------
	// Checks on sequencing
	// ----------------------------------------
	// The controller reset is released only in run and park
	AST_RESET_OUT: assert property (@(posedge clock) disable iff (!rst_n) // see [R6]
		ctrl_reset_n == ((state_reg == PGSC_RUN) || (state_reg == PGSC_PARK)))
		else $error("Controller reset output disagrees with the power state");
	// The park request stands exactly while parked
	AST_PARK_LEVEL: assert property (@(posedge clock) disable iff (!rst_n) // see [R4]
		park_req == (state_reg == PGSC_PARK))
		else $error("Park request disagrees with the power state");
	// Without a done pulse the park runs its full length
	AST_PARK_LEN: assert property (@(posedge clock) disable iff (!rst_n) // see [R4]
		(state_reg == PGSC_PARK) && !park_over |=> (state_reg == PGSC_PARK))
		else $error("Park ended before its length or a done pulse");
	// A park never outlasts its counted length
	AST_PARK_BOUND: assert property (@(posedge clock) disable iff (!rst_n) // see [R4]
		(state_reg == PGSC_PARK) |-> park_cnt_reg <= PARK_LIM)
		else $error("Park ran past its counted length");

	// ----------------------------------------
	// Checks on mode and synchroniser
	// ----------------------------------------
	// Active and standby are never shown together
	AST_MODE_EXCL: assert property (@(posedge clock) disable iff (!rst_n) // see [R11]
		active_mode != standby_mode)
		else $error("Active and standby modes shown together");
	// Supply status lags the pin by both sync stages and its own register
	AST_SENSE_SYNC: assert property (@(posedge clock) disable iff (!rst_n) // see [R12]
		supply_ok |-> $past(supply_sense_in, 3))
		else $error("Supply status skipped the synchroniser");
	// The standby request passes both stages as well
	AST_STBY_SYNC: assert property (@(posedge clock) disable iff (!rst_n) // see [R12]
		standby_s |-> $past(standby_req_in, 2))
		else $error("Standby request skipped the synchroniser");
endmodule : pgsc_top

// [shared/pgsc_cfg.svh]
// Notes on behaviour
// [R1] A qualified high on power good means all supplies are in range and reset may be left.
// [R2] The supply monitor drops power good at least 0.5 ms before any supply falls out of range.
// [R3] The monitor keeps supply sense high through the warning interval after power good falls.
// [R4] A power good low lasting at least 4 us starts a park, followed by a full controller reset.
// [R5] Low pulses on power good shorter than 4 us are ignored as glitches.
// [R6] After park and reset the controller stays in reset for as long as power good is low.
// [R7] Power good counts as asserted only after being high continuously for at least 625 ns.
// [R8] The monitor drives supply sense low whenever any supply is below its minimum.
// [R9] The monitor holds supply sense high while all supplies stay above their minimum.
// [R10] A high standby request input commands active mode; the code gives active mode only in the run state.
// [R11] A low standby request input commands standby mode.
// [R12] Every asynchronous input passes a two-stage synchroniser before qualification.
`ifndef PGSC_CFG_SVH
`define PGSC_CFG_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define PGSC_CLK_PERIOD_PS 10000
`define PGSC_LOW_MIN_NS 4000
`define PGSC_HIGH_MIN_NS 625
`define PGSC_WARN_US 500
// Least times round up to whole cycles
`define PGSC_LOW_CYC ((`PGSC_LOW_MIN_NS * 1000 + `PGSC_CLK_PERIOD_PS - 1) / `PGSC_CLK_PERIOD_PS)
`define PGSC_HIGH_CYC ((`PGSC_HIGH_MIN_NS * 1000 + `PGSC_CLK_PERIOD_PS - 1) / `PGSC_CLK_PERIOD_PS)
`define PGSC_PARK_CYC 16
`define PGSC_CNT_W 12
`endif

// [shared/pgsc_pkg.sv]
package pgsc_pkg;
	typedef enum logic [2:0] {
		PGSC_RESET = 3'b000,
		PGSC_RUN = 3'b001,
		PGSC_PARK = 3'b010,
		PGSC_HOLD = 3'b011
	} pgsc_state_e;
endpackage : pgsc_pkg

// [shared/pgsc_sync_if.sv]
`timescale 1ns/1ps
interface pgsc_sync_if;
	logic pg_s;
	logic sense_s;
	logic standby_s;
	modport src (output pg_s, output sense_s, output standby_s);
	modport dst (input pg_s, input sense_s, input standby_s);
endinterface : pgsc_sync_if

// [rtl/pgsc_sync.sv]
`timescale 1ns/1ps
module pgsc_sync (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Raw pins
	input wire logic power_good_in,
	input wire logic supply_sense_in,
	input wire logic standby_req_in,
	// Synchronised levels
	pgsc_sync_if.src sync
);
	logic [2:0] meta_reg;
	logic [2:0] stab_reg;
	// Two flops per input; only the second stage is read
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= 3'h0;
			stab_reg <= 3'h0;
		end else begin
			meta_reg <= {standby_req_in, supply_sense_in, power_good_in}; // see [R12]
			stab_reg <= meta_reg;
		end
	end
	assign sync.pg_s = stab_reg[0];
	assign sync.sense_s = stab_reg[1];
	assign sync.standby_s = stab_reg[2];
endmodule : pgsc_sync

// [test/pgsc_supply_model.sv]
`timescale 1ns/1ps
module pgsc_supply_model #(
	parameter int WARN_CYC = 20
) (
	// Clock
	input wire logic clock,
	// Commands from the bench
	input wire logic pg_cmd,
	input wire logic rails_ok,
	input wire logic stby_cmd,
	// Pins toward the block
	output logic power_good_in,
	output logic supply_sense_in,
	output logic standby_req_in
);
	int warn_cnt = 0;
	// ----------------------------------------
	// Early warning
	// ----------------------------------------
	// Warning interval restarts while power good is high, runs out after it falls
	always @(negedge clock) begin
		if (pg_cmd) begin
			warn_cnt <= WARN_CYC;
		end else if (warn_cnt > 0) begin
			warn_cnt <= warn_cnt - 1;
		end
	end
	// Sense held high through the warning after a fall, otherwise follows the rails
	assign supply_sense_in = rails_ok || (!pg_cmd && (warn_cnt > 0));
	assign power_good_in = pg_cmd;
	assign standby_req_in = stby_cmd;
endmodule : pgsc_supply_model

// [test/pgsc_top_tb.sv]
`timescale 1ns/1ps
module pgsc_top_tb;
	logic clock;
	logic rst_n;
	logic pg_cmd;
	logic rails_ok;
	logic stby_cmd;
	logic park_done;
	logic power_good_in, supply_sense_in, standby_req_in;
	logic ctrl_reset_n, park_req, active_mode, standby_mode, power_good_ok, supply_ok;
	wire logic [5:0] outs = {power_good_ok, ctrl_reset_n, park_req, active_mode, standby_mode,
		supply_ok};
	logic [5:0] expq[$];
	logic [5:0] last_trig = 6'h02;
	int miscompares = 0;
	int samples_checked = 0;
	// ----------------------------------------
	// Clock and instances
	// ----------------------------------------
	always #5 clock = ~clock;
	pgsc_top i_pgsc_top (.clock(clock), .rst_n(rst_n),
		.power_good_in(power_good_in), .supply_sense_in(supply_sense_in),
		.standby_req_in(standby_req_in), .park_done(park_done), .ctrl_reset_n(ctrl_reset_n),
		.park_req(park_req), .active_mode(active_mode), .standby_mode(standby_mode),
		.power_good_ok(power_good_ok), .supply_ok(supply_ok));
	pgsc_supply_model i_pgsc_supply_model (.clock(clock), .pg_cmd(pg_cmd), .rails_ok(rails_ok),
		.stby_cmd(stby_cmd), .power_good_in(power_good_in), .supply_sense_in(supply_sense_in),
		.standby_req_in(standby_req_in));
	// ----------------------------------------
	// Checking
	// ----------------------------------------
	task automatic compare_vec(input logic [5:0] got, input logic [5:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : compare_vec
	task automatic finish_test();
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : finish_test
	// Each change of any output takes the oldest note; a change with none noted fails
	always @(negedge clock) begin
		if (rst_n && (outs !== last_trig)) begin
			last_trig = outs;
			if (expq.size() == 0) begin
				compare_vec(outs, 6'h3f);
			end else begin
				compare_vec(outs, expq.pop_front());
			end
		end
	end
	// ----------------------------------------
	// Stimulus
	// ----------------------------------------
	task automatic drive(input logic lvl, input int n);
		pg_cmd = lvl;
		repeat (n) @(negedge clock);
	endtask : drive
	task automatic drain();
		for (int i = 0; i < 200 && expq.size() > 0; i++) begin
			@(negedge clock);
		end
		if (expq.size() > 0) begin
			miscompares++;
			finish_test();
		end
	endtask : drain
	initial begin
		clock = 1'b0;
		rst_n = 1'b0;
		pg_cmd = 1'b0;
		rails_ok = 1'b1;
		stby_cmd = 1'b0;
		park_done = 1'b0;
		void'($urandom(18855));
		expq.push_back(6'h03);
		repeat (20) @(negedge clock);
		rst_n = 1'b1;
		drive(1'b1, $urandom_range(60, 1));
		drive(1'b0, 4);
		expq.push_back(6'h23);
		expq.push_back(6'h33);
		drive(1'b1, 80);
		drain();
		expq.push_back(6'h35);
		stby_cmd = 1'b1;
		drain();
		expq.push_back(6'h33);
		stby_cmd = 1'b0;
		drain();
		drive(1'b0, $urandom_range(390, 1));
		drive(1'b1, 10);
		expq.push_back(6'h13);
		expq.push_back(6'h1b);
		expq.push_back(6'h03);
		drive(1'b0, 460);
		drain();
		expq.push_back(6'h23);
		expq.push_back(6'h33);
		drive(1'b1, 80);
		drain();
		expq.push_back(6'h13);
		expq.push_back(6'h1b);
		expq.push_back(6'h03);
		drive(1'b0, 405);
		park_done = 1'b1;
		@(negedge clock);
		park_done = 1'b0;
		compare_vec(outs, 6'h03);
		drive(1'b0, 30);
		expq.push_back(6'h02);
		rails_ok = 1'b0;
		drive(1'b0, 30);
		expq.push_back(6'h22);
		drive(1'b1, 100);
		drain();
		finish_test();
	end
endmodule : pgsc_top_tb
